// *** rtl/pml_port_pin_mode.sv ***
`timescale 1ns/1ns
`include "pml_map.svh"
// Functional notes
// - Drive-style bit n: 0 open-drain, 1 push-pull for pin n.
// - Latch 0 drives low; latch 1 drives high only in push-pull.
// - Latch reaches pin only where routing leaves pin unclaimed by peripherals.
// - Data register reads, except read-modify-write, return actual levels of digital pins, ignoring routing.
// - Ports 1-3 latches: eight bits, reset all ones, bit and byte writable.
// - Select bit 0: analog, digital read gives 0, pullup off.
// - Select bit 1: digital, read gives level, pullup follows global disable.
// - Two-wire and mode-0 receive pins always open-drain.
// - Port 1 analog pins skipped when peripherals are assigned.
// - Port 1 analog pins still driven by latch and drive style.
// - Memory interface may drive port 1 with upper address, non-multiplexed.
// - Memory interface may drive port 2 with upper or lower address.
// - Memory interface may use port 3 as address/data or data bus.
// - Drive styles reset to zero, selects reset to all ones.
// - Crossbar disabled forces every pin to input.
// - Global pullup disable 1 turns all pullups off.
// - Pullup off while a pin actively drives low.
module pml_port_pin_mode
  import pml_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      sys_rst,
  input  wire pml_byte_t sfr_addr,
  input  wire logic      sfr_wr,
  input  wire pml_byte_t sfr_wdata,
  input  wire logic      sfr_rd,
  input  wire logic      sfr_rmw,
  input  wire pml_byte_t bit_addr,
  input  wire logic      bit_wr,
  input  wire logic      bit_wdata,
  output logic           sfr_rdata_vld,
  output pml_byte_t      sfr_rdata,
  input  wire logic      crossbar_enable,
  input  wire logic      global_pullup_disable,
  input  wire pml_pins_t periph_claim,
  input  wire pml_pins_t periph_out,
  input  wire pml_pins_t periph_force_od,
  input  wire pml_pins_t emif_claim,
  input  wire pml_pins_t emif_out,
  input  wire pml_pins_t emif_drive,
  input  wire pml_pins_t pin_in,
  output pml_pins_t      pin_out,
  output pml_pins_t      pin_oe,
  output pml_pins_t      pin_pullup_en,
  output pml_pins_t      port1_analog_skip,
  output pml_byte_t      port0_drive_style
);

  // ----------------------------------------
  // Configuration and latch storage
  // ----------------------------------------
  logic [2:0][7:0] latch_all;
  logic [3:0][7:0] style_all;
  logic [2:0][7:0] select_all;
  logic [2:0]      latch_byte_hit;
  logic [2:0]      latch_bit_hit;
  logic [3:0]      style_hit;
  logic [2:0]      select_hit;
  pml_pins_t       rd_flat;
  pml_pins_t sync1_ff;
  pml_pins_t sync2_ff;
  pml_pins_t pin_out_ff;
  pml_pins_t pin_oe_ff;
  pml_pins_t pullup_ff;
  pml_pins_t skip_ff;
  pml_byte_t rdata_ff;
  logic      rdata_vld_ff;

  pml_pins_t latch_flat;
  pml_pins_t style_flat;
  pml_pins_t select_flat;
  pml_pins_t level_flat;
  pml_pins_t nxt_pin_out;
  pml_pins_t nxt_pin_oe;
  pml_pins_t nxt_pullup;
  pml_pins_t nxt_skip;
  pml_byte_t nxt_rdata;

  assign latch_flat  = latch_all;
  assign style_flat  = {style_all[3], style_all[2], style_all[1]};
  assign select_flat = select_all;

  // ----------------------------------------
  // Register address tables, one entry per port
  // ----------------------------------------
  localparam pml_byte_t  LATCH_ADDR [3] = '{
    `PML_P1_LATCH_ADDR,
    `PML_P2_LATCH_ADDR,
    `PML_P3_LATCH_ADDR
  };

  localparam logic [4:0] BIT_BASE [3] = '{
    `PML_P1_BIT_BASE,
    `PML_P2_BIT_BASE,
    `PML_P3_BIT_BASE
  };

  localparam pml_byte_t  SELECT_ADDR [3] = '{
    `PML_P1_SELECT_ADDR,
    `PML_P2_SELECT_ADDR,
    `PML_P3_SELECT_ADDR
  };

  localparam pml_byte_t  STYLE_ADDR [4] = '{
    `PML_P0_STYLE_ADDR,
    `PML_P1_STYLE_ADDR,
    `PML_P2_STYLE_ADDR,
    `PML_P3_STYLE_ADDR
  };

  // ----------------------------------------
  // Output latches and analog or digital selects
  // ----------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_port
    pml_byte_t latch_ff;
    pml_byte_t select_ff;

    assign latch_byte_hit[p] = sfr_wr & (sfr_addr == LATCH_ADDR[p]);
    assign latch_bit_hit[p]  = bit_wr & (bit_addr[7:3] == BIT_BASE[p]);
    assign select_hit[p]     = sfr_wr & (sfr_addr == SELECT_ADDR[p]);

    // Byte and bit write in one cycle: bit write lands last
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        latch_ff <= `PML_LATCH_RST;
      end else begin
        if (latch_byte_hit[p]) begin
          latch_ff <= sfr_wdata;
        end
        if (latch_bit_hit[p]) begin
          latch_ff[bit_addr[2:0]] <= bit_wdata;
        end
      end
    end

    // Select bit 0 blanks the read bit and the pullup
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        select_ff <= `PML_SELECT_RST;
      end else if (select_hit[p]) begin
        select_ff <= sfr_wdata;
      end
    end

    assign latch_all[p]  = latch_ff;
    assign select_all[p] = select_ff;
  end

  // ----------------------------------------
  // Drive style registers, ports 0 to 3
  // ----------------------------------------
  for (genvar q = 0; q < 4; q++) begin : g_style
    pml_byte_t style_ff;

    assign style_hit[q] = sfr_wr & (sfr_addr == STYLE_ADDR[q]);

    // Port 0 style is only exported, no pins here
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        style_ff <= `PML_STYLE_RST;
      end else if (style_hit[q]) begin
        style_ff <= sfr_wdata;
      end
    end

    assign style_all[q] = style_ff;
  end

  // ----------------------------------------
  // Pin level synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= `PML_PINS_RST;
      sync2_ff <= `PML_PINS_RST;
    end else begin
      // Only sync2_ff is read downstream
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------
  // Per-pin driver and pullup control
  // ----------------------------------------
  // Port 1 positions in the flat pin vectors
  localparam pml_pins_t P1_MASK = `PML_P1_PINS;

  for (genvar i = 0; i < 24; i++) begin : g_pin
    localparam logic IS_P1 = P1_MASK[i];
    // Analog port 1 pins are never handed to peripherals
    logic analog;
    logic claim;
    logic src;
    logic od;
    logic drv;

    assign analog = ~select_flat[i];
    assign claim  = periph_claim[i] & ~(IS_P1 & analog);
    // Memory interface outranks peripherals and latch
    assign src    = emif_claim[i] ? emif_out[i] :
                    claim ? periph_out[i] : latch_flat[i];
    assign od     = ~style_flat[i] | (claim & periph_force_od[i]);
    assign drv    = crossbar_enable & (~src | ~od) &
                    (~emif_claim[i] | emif_drive[i]);
    assign nxt_pin_out[i] = src;
    assign nxt_pin_oe[i]  = drv;
    assign nxt_pullup[i]  = ~global_pullup_disable & select_flat[i] &
                            ~(drv & ~src);
    assign nxt_skip[i]    = IS_P1 & analog;
    assign level_flat[i]  = sync2_ff[i] & select_flat[i];
  end

  // ----------------------------------------
  // Registered pin controls
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out_ff <= `PML_PINS_RST;
      pin_oe_ff  <= `PML_PINS_RST;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
    end
  end

  // Pullups stay off in reset until the config is known
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pullup_ff <= `PML_PINS_RST;
    end else begin
      pullup_ff <= nxt_pullup;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      skip_ff <= `PML_PINS_RST;
    end else begin
      skip_ff <= nxt_skip;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_rd
    // Read-modify-write sees the latch, not the pin
    assign rd_flat[p*8 +: 8] = sfr_rmw ? latch_all[p] : level_flat[p*8 +: 8];
  end

  always_comb begin
    case (sfr_addr)
      `PML_P1_LATCH_ADDR:  nxt_rdata = rd_flat[7:0];
      `PML_P2_LATCH_ADDR:  nxt_rdata = rd_flat[15:8];
      `PML_P3_LATCH_ADDR:  nxt_rdata = rd_flat[23:16];
      `PML_P0_STYLE_ADDR:  nxt_rdata = style_all[0];
      `PML_P1_STYLE_ADDR:  nxt_rdata = style_all[1];
      `PML_P2_STYLE_ADDR:  nxt_rdata = style_all[2];
      `PML_P3_STYLE_ADDR:  nxt_rdata = style_all[3];
      `PML_P1_SELECT_ADDR: nxt_rdata = select_all[0];
      `PML_P2_SELECT_ADDR: nxt_rdata = select_all[1];
      `PML_P3_SELECT_ADDR: nxt_rdata = select_all[2];
      default:             nxt_rdata = `PML_RDATA_RST;
    endcase
  end

  // Valid pulses one cycle after each read strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_vld_ff <= 1'b0;
    end else begin
      rdata_vld_ff <= sfr_rd;
    end
  end

  // Data holds until the next read
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= `PML_RDATA_RST;
    end else if (sfr_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sfr_rdata         = rdata_ff;
  assign sfr_rdata_vld     = rdata_vld_ff;
  assign pin_out           = pin_out_ff;
  assign pin_oe            = pin_oe_ff;
  assign pin_pullup_en     = pullup_ff;
  assign port1_analog_skip = skip_ff;
  // Port 0 style drives the port 0 output stage elsewhere
  assign port0_drive_style = style_all[0];

endmodule : pml_port_pin_mode

// *** rtl/pml_map.svh ***
`ifndef PML_MAP_SVH
`define PML_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PML_P1_LATCH_ADDR  8'h90
`define PML_P2_LATCH_ADDR  8'ha0
`define PML_P3_LATCH_ADDR  8'hb0
`define PML_P0_STYLE_ADDR  8'ha4
`define PML_P1_STYLE_ADDR  8'ha5
`define PML_P2_STYLE_ADDR  8'ha6
`define PML_P3_STYLE_ADDR  8'ha7
`define PML_P1_SELECT_ADDR 8'had
`define PML_P2_SELECT_ADDR 8'hae
`define PML_P3_SELECT_ADDR 8'haf

// ----------------------------------------
// Bit address bases (address bits 7:3)
// ----------------------------------------
`define PML_P1_BIT_BASE 5'h12
`define PML_P2_BIT_BASE 5'h14
`define PML_P3_BIT_BASE 5'h16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PML_LATCH_RST  8'hff
`define PML_STYLE_RST  8'h00
`define PML_SELECT_RST 8'hff
`define PML_RDATA_RST  8'h00
`define PML_PINS_RST   24'h000000
`define PML_P1_PINS    24'h0000ff

`endif

// *** rtl/pml_pkg.sv ***
package pml_pkg;

  typedef logic [7:0]  pml_byte_t;
  typedef logic [23:0] pml_pins_t;

endpackage : pml_pkg

// *** sim/pml_port_pin_mode_asserts.sv ***
`timescale 1ns/1ns
module pml_pin_chk
  import pml_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      sys_rst,
  input wire logic      sfr_rd,
  input wire logic      sfr_rdata_vld,
  input wire pml_byte_t sfr_rdata,
  input wire logic      crossbar_enable,
  input wire logic      global_pullup_disable,
  input wire pml_pins_t periph_claim,
  input wire pml_pins_t periph_force_od,
  input wire pml_pins_t emif_claim,
  input wire pml_pins_t emif_drive,
  input wire pml_pins_t pin_out,
  input wire pml_pins_t pin_oe,
  input wire pml_pins_t pin_pullup_en,
  input wire pml_pins_t port1_analog_skip
);
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  AST_XBAR_OFF: assert property (!crossbar_enable |=> pin_oe == 24'h0)
    else $error("driving with crossbar off");
  AST_PUD: assert property (global_pullup_disable |=> pin_pullup_en == 24'h0)
    else $error("pullup while disabled");
  AST_PULL_LOW: assert property ((pin_pullup_en & pin_oe & ~pin_out) == 24'h0)
    else $error("pullup on low pin");
  AST_RD_VLD: assert property (1'b1 |=> sfr_rdata_vld == $past(sfr_rd))
    else $error("read valid timing");
  AST_RD_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  AST_EMIF_RD: assert property (1'b1 |=>
    (pin_oe & $past(emif_claim) & ~$past(emif_drive)) == 24'h0)
    else $error("drive during memory read");
  AST_FORCE_OD: assert property (1'b1 |=> (pin_oe & pin_out & $past(periph_claim)
    & $past(periph_force_od) & ~$past(emif_claim) & 24'hffff00) == 24'h0)
    else $error("forced pin driven high");
  AST_SKIP_HI: assert property (port1_analog_skip[23:8] == 16'h0)
    else $error("skip outside port 1");
  cover property (sfr_rd ##1 sfr_rdata_vld);
  cover property (!crossbar_enable ##1 crossbar_enable);
  cover property ((emif_claim & ~emif_drive) != 24'h0);
endmodule : pml_pin_chk
bind pml_port_pin_mode pml_pin_chk i_pml_pin_chk (.*);

// *** sim/pml_pin_ext.sv ***
`timescale 1ns/1ns
module pml_pin_ext
  import pml_pkg::*;
(
  input wire logic      ref_clk,
  input wire pml_pins_t pin_out,
  input wire pml_pins_t pin_oe,
  input wire pml_pins_t pin_pullup_en,
  input wire pml_pins_t ext_drv,
  input wire pml_pins_t ext_val,
  output pml_pins_t     pin_level
);
  pml_pins_t flt_ff = 24'h5a5a5a;
  // Undriven pins without pullup wander
  always @(posedge ref_clk) flt_ff <= ~flt_ff;
  assign pin_level = (pin_oe & pin_out) |
    (~pin_oe & ((ext_drv & ext_val) | (~ext_drv & (pin_pullup_en | flt_ff))));
endmodule : pml_pin_ext

// *** sim/pml_port_pin_mode_tb.sv ***
`timescale 1ns/1ns
module pml_port_pin_mode_tb;
  import pml_pkg::*;
  logic      ref_clk, sys_rst, sfr_wr, sfr_rd, sfr_rmw, bit_wr, bit_wdata, vld, xe, pud;
  pml_byte_t sfr_addr, sfr_wdata, bit_addr, rdata, p0s;
  pml_pins_t pc, po, pf, ec, eo, ed, xd, xv, pin_in, pin_out, pin_oe, pu, skip;
  pml_byte_t ra [10] = '{8'h90, 8'ha0, 8'hb0, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'had, 8'hae, 8'haf};
  int        n_errors, checked;
  pml_port_pin_mode i_pml_port_pin_mode (
    .ref_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rmw, .bit_addr, .bit_wr,
    .bit_wdata, .sfr_rdata_vld(vld), .sfr_rdata(rdata), .crossbar_enable(xe),
    .global_pullup_disable(pud), .periph_claim(pc), .periph_out(po), .periph_force_od(pf),
    .emif_claim(ec), .emif_out(eo), .emif_drive(ed), .pin_in, .pin_out, .pin_oe,
    .pin_pullup_en(pu), .port1_analog_skip(skip), .port0_drive_style(p0s)
  );
  pml_pin_ext i_pml_pin_ext (
    .ref_clk, .pin_out, .pin_oe, .pin_pullup_en(pu), .ext_drv(xd), .ext_val(xv),
    .pin_level(pin_in)
  );
  task finish_test;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task chk(input pml_pins_t g, input pml_pins_t e);
    checked++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      n_errors++;
    end
  endtask : chk
  task tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tk
  task wr(input pml_byte_t a, input pml_byte_t v);
    @(posedge ref_clk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task rd(input pml_byte_t a, input logic m, input pml_byte_t e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rmw  <= m;
    sfr_rd   <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    chk({23'h0, vld}, 24'h000001);
    chk({16'h0, rdata}, {16'h0, e});
  endtask : rd
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end
  initial begin
    {sys_rst, sfr_wr, sfr_rd, sfr_rmw, bit_wr, bit_wdata, xe, pud} = 8'h80;
    {sfr_addr, sfr_wdata, bit_addr} = '0;
    {pc, po, pf, ec, eo, ed, xd, xv} = '0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], 1'b1, (i < 3 || i > 6) ? 8'hff : 8'h00);
    rd(8'h91, 1'b0, 8'h00);
    wr(8'ha4, 8'h5a);
    tk(1);
    chk({16'h0, p0s}, 24'h00005a);
    xe <= 1'b1;
    wr(8'h90, 8'h0f);
    tk(4);
    chk(pin_oe, 24'h0000f0);
    rd(8'h90, 1'b0, 8'h0f);
    wr(8'ha5, 8'hff);
    tk(2);
    chk(pin_oe, 24'h0000ff);
    wr(8'h90, 8'hff);
    wr(8'ha5, 8'h00);
    xd <= 24'h0000ff;
    xv <= 24'h0000aa;
    wr(8'had, 8'h0f);
    tk(4);
    rd(8'h90, 1'b0, 8'h0a);
    chk(pu, 24'hffff0f);
    chk(skip, 24'h0000f0);
    pc <= 24'h0000ff;
    tk(2);
    chk(pin_oe, 24'h00000f);
    pud <= 1'b1;
    pc <= '0;
    xd <= '0;
    tk(2);
    chk(pu, 24'h0);
    @(posedge ref_clk);
    bit_addr  <= {5'h14, 3'd2};
    bit_wdata <= 1'b0;
    bit_wr    <= 1'b1;
    @(posedge ref_clk);
    bit_wr <= 1'b0;
    rd(8'ha0, 1'b1, 8'hfb);
    chk(pin_oe, 24'h000400);
    wr(8'ha7, 8'hff);
    pc <= 24'hff0000;
    po <= 24'h550000;
    pf <= 24'h0f0000;
    tk(2);
    chk(pin_out & 24'hff0000, 24'h550000);
    chk(pin_oe, 24'hfa0400);
    wr(8'ha6, 8'hff);
    ec <= 24'h00ffff;
    eo <= 24'h003c81;
    ed <= 24'h00ffff;
    tk(2);
    chk(pin_out & 24'h00ffff, 24'h003c81);
    chk(pin_oe & 24'h00ffff, 24'h00ff7e);
    ed <= '0;
    tk(2);
    chk(pin_oe & 24'h00ffff, 24'h0);
    xe <= 1'b0;
    tk(2);
    chk(pin_oe, 24'h0);
    finish_test();
  end
endmodule : pml_port_pin_mode_tb
